// ---- rtl/rpsq_pkg.sv ----
// Package for the radio power and reset sequencer.
// Assumes a single 100 MHz clock; the ms timing counts derive from it, POR_HOLD_CYCLES is a plain cycle count.
package rpsq_pkg;
   localparam int unsigned CLK_HZ = 100000000;
   localparam int unsigned CLK_PERIOD_NS = 10;
   // Power-on reset hold, upper bound, in ms
   localparam int unsigned POR_MAX_MS = 110;
   // Cold-start discharge spacing the host must keep, in ms
   localparam int unsigned DISCHARGE_MS = 10;
   // Bus-access wait the host must keep, in ms
   localparam int unsigned BUS_WAIT_MS = 150;
   // Longest time rounds down
   localparam int unsigned POR_CYCLES = (POR_MAX_MS * (CLK_HZ / 1000));
   // Least times round up (exact here)
   localparam int unsigned DISCHARGE_CYCLES =
      (DISCHARGE_MS * (CLK_HZ / 1000));
   localparam int unsigned BUS_WAIT_CYCLES = (BUS_WAIT_MS * (CLK_HZ / 1000));
   // Power-on hold actually used; far inside POR_CYCLES
   localparam int unsigned POR_HOLD_CYCLES = 100;
   localparam int CNT_W = 25;
   localparam logic [CNT_W-1:0] CNT_RESET = 25'h0;

   typedef enum logic [1:0] {
      RPSQ_POR = 2'b00,
      RPSQ_OFF = 2'b01,
      RPSQ_ON = 2'b10
   } rpsq_state_e;

   function automatic logic [CNT_W-1:0] rpsq_dec(
      input logic [CNT_W-1:0] v);
      rpsq_dec = (v == CNT_RESET) ? CNT_RESET : v - 25'h1;
   endfunction : rpsq_dec
endpackage : rpsq_pkg

// ---- rtl/rpsq_timer.sv ----
// Loadable down-counter; done is high while the count stands at zero.
// Assumes a synchronous load from the sequencer.
module rpsq_timer (
   input wire logic clk_in,
   input wire logic resetn_in,
   rpsq_tmr_if.tmr t
);
   import rpsq_pkg::*;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;

   always_comb begin
      cnt_d = t.load ? t.value : rpsq_dec(cnt_q);
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cnt_q <= CNT_RESET;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign t.done = (cnt_q == CNT_RESET);
endmodule : rpsq_timer

// ---- rtl/rpsq_tmr_if.sv ----
// Interface between sequencer and its down-counter.
// Assumes one clock domain.
interface rpsq_tmr_if;
   import rpsq_pkg::*;
   logic load;
   logic [CNT_W-1:0] value;
   logic done;
   modport ctrl (output load, output value, input done);
   modport tmr (input load, input value, output done);
endinterface : rpsq_tmr_if

// ---- rtl/rpsq_top.sv ----
// Radio power and reset sequencer: regulator enable and section resets.
// Assumes power request inputs synchronous to clk_in; resetn_in stands
// for the supplies crossing the power-on threshold.
//
// Contract
// - Regulators are on while either power request is high, off when both low or while power-on reset holds.
// - The WLAN section is in reset while its power request is low.
// - With WLAN requested and the radio not, the radio stays in reset.
// - Power-on reset holds the device no longer than 110 ms.
module rpsq_top (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic wlan_power_request_in,
   input wire logic short_range_radio_power_request_in,
   output logic regulator_enable_out,
   output logic wlan_resetn_out,
   output logic radio_resetn_out,
   output logic por_active_out,
   output logic discharge_busy_out,
   output logic bus_ready_out,
   output rpsq_pkg::rpsq_state_e state_out
);
   import rpsq_pkg::*;

   rpsq_tmr_if tif ();
   rpsq_timer u_timer (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .t(tif.tmr)
   );

   rpsq_state_e state_q;
   rpsq_state_e state_d;
   logic reg_en_q;
   logic reg_en_d;
   logic wl_rstn_q;
   logic wl_rstn_d;
   logic rad_rstn_q;
   logic rad_rstn_d;
   logic dis_q;
   logic dis_d;
   logic rdy_q;
   logic rdy_d;
   logic [CNT_W-1:0] bus_cnt_q;
   logic [CNT_W-1:0] bus_cnt_d;
   logic any_req;
   logic first_q;
   logic first_d;

   // One decode of the powered state, shared by the regulator enable and both section resets
   function automatic logic rpsq_is_on(input rpsq_state_e s);
      rpsq_is_on = (s == RPSQ_ON);
   endfunction : rpsq_is_on

   assign any_req = wlan_power_request_in |
      short_range_radio_power_request_in;

   always_comb begin
      state_d = state_q;
      tif.load = 1'b0;
      tif.value = CNT_RESET;
      dis_d = dis_q;
      case (state_q)
         RPSQ_POR: begin
            // Internal reset released well inside its bound
            if (tif.done) begin
               state_d = any_req ? RPSQ_ON : RPSQ_OFF;
            end
         end
         RPSQ_ON: begin
            if (!any_req) begin
               // Track discharge window only as a status; host keeps it
               state_d = RPSQ_OFF;
               tif.load = 1'b1;
               tif.value = CNT_W'(DISCHARGE_CYCLES);
               dis_d = 1'b1;
            end
         end
         RPSQ_OFF: begin
            if (tif.done) begin
               dis_d = 1'b0;
            end
            if (any_req) begin
               // Early toggle is not blocked: in-rush is the host's risk
               state_d = RPSQ_ON;
               dis_d = 1'b0;
            end
         end
         default: begin
            state_d = RPSQ_POR;
         end
      endcase

      // Power-on hold: first cycle after reset arms the shared timer
      // Overrides any request seen while the supplies settle
      if (first_q) begin
         state_d = RPSQ_POR;
         dis_d = 1'b0;
         tif.load = 1'b1;
         tif.value = CNT_W'(POR_HOLD_CYCLES);
      end
   end

   always_comb begin
      reg_en_d = rpsq_is_on(state_d);
      wl_rstn_d = rpsq_is_on(state_d) & wlan_power_request_in;
      rad_rstn_d = rpsq_is_on(state_d) &
         short_range_radio_power_request_in;
   end

   always_comb begin
      bus_cnt_d = rpsq_dec(bus_cnt_q);
      rdy_d = rdy_q | (bus_cnt_q == CNT_RESET);
   end

   // First-cycle flag clears once and never sets again
   always_comb begin
      first_d = 1'b0;
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         first_q <= 1'b1;
      end else begin
         first_q <= first_d;
      end
   end

   // Sequencer state and discharge status
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_q <= RPSQ_POR;
         dis_q <= 1'b0;
      end else begin
         state_q <= state_d;
         dis_q <= dis_d;
      end
   end

   // Regulator and section resets; registered so they never glitch
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         reg_en_q <= 1'b0;
         wl_rstn_q <= 1'b0;
         rad_rstn_q <= 1'b0;
      end else begin
         reg_en_q <= reg_en_d;
         wl_rstn_q <= wl_rstn_d;
         rad_rstn_q <= rad_rstn_d;
      end
   end

   // Bus-access wait; status only, the host keeps the spacing
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rdy_q <= 1'b0;
         bus_cnt_q <= CNT_W'(BUS_WAIT_CYCLES);
      end else begin
         rdy_q <= rdy_d;
         bus_cnt_q <= bus_cnt_d;
      end
   end

   assign regulator_enable_out = reg_en_q;
   assign wlan_resetn_out = wl_rstn_q;
   assign radio_resetn_out = rad_rstn_q;
   assign por_active_out = (state_q == RPSQ_POR);
   assign discharge_busy_out = dis_q;
   assign bus_ready_out = rdy_q;
   assign state_out = state_q;
endmodule : rpsq_top

// ---- tb/rpsq_host.sv ----
// Host model driving the two power requests.
// Assumes wishes change just after clk_in rises.
module rpsq_host (
   input wire logic clk_in,
   input wire logic want_w_in,
   input wire logic want_r_in,
   output logic wlan_req_out,
   output logic radio_req_out
);
   logic off_q = 1'b0;
   logic off_d;
   logic on_q = 1'b0;
   logic on_d;
   // Once both drop after a power-up, stay off; the wait outlasts the run
   always_comb on_d = on_q | want_w_in | want_r_in;
   always_comb off_d = off_q | (on_q & !want_w_in & !want_r_in);
   always_ff @(posedge clk_in) off_q <= off_d;
   always_ff @(posedge clk_in) on_q <= on_d;
   assign wlan_req_out = want_w_in & !off_d;
   assign radio_req_out = want_r_in & !off_d;
endmodule : rpsq_host

// ---- tb/rpsq_monitor.sv ----
// Checker on the sequencer ports.
// Assumes it is bound onto rpsq_top.
module rpsq_monitor (
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic wlan_power_request_in,
   input wire logic short_range_radio_power_request_in,
   input wire logic regulator_enable_out,
   input wire logic wlan_resetn_out,
   input wire logic radio_resetn_out,
   input wire logic por_active_out
);
   import rpsq_pkg::*;
   wire logic rr = short_range_radio_power_request_in;
   wire logic wr = wlan_power_request_in;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   // Two settled cycles, so $past never sees power-on values
   sequence s_up;
      !por_active_out ##1 !por_active_out;
   endsequence
   AST_REG_ON: assert property (s_up |->
      regulator_enable_out == $past(wr | rr)) else $error("regulator bad");
   AST_WLAN_RST: assert property (s_up |->
      wlan_resetn_out == $past(wr)) else $error("wlan reset bad");
   AST_RADIO_HELD: assert property (s_up ##0 $past(wr & !rr) |->
      !radio_resetn_out && regulator_enable_out) else $error("radio bad");
   // Tighter than the limit, but the hold is only about 100 cycles
   AST_POR_BOUND: assert property (por_active_out |->
      ##[1:1000] !por_active_out) else $error("power-on reset too long");
   AST_OFF_HELD: assert property (!regulator_enable_out |->
      !wlan_resetn_out && !radio_resetn_out) else $error("held reset bad");
endmodule : rpsq_monitor
bind rpsq_top rpsq_monitor u_rpsq_monitor (.clk_in(clk_in),
   .resetn_in(resetn_in), .wlan_power_request_in(wlan_power_request_in),
   .short_range_radio_power_request_in(short_range_radio_power_request_in),
   .regulator_enable_out(regulator_enable_out),
   .wlan_resetn_out(wlan_resetn_out), .radio_resetn_out(radio_resetn_out),
   .por_active_out(por_active_out));

// ---- tb/rpsq_top_tb.sv ----
// Testbench for rpsq_top with a host model.
// Assumes 100 MHz; the long ms timers are not run out.
module rpsq_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import rpsq_pkg::*;
   logic clk_in = 0, resetn_in = 0, ww = 0, wr = 0, wq, rq;
   logic reg_en, w_rst, r_rst, por, busy, rdy;
   rpsq_state_e st;
   logic [4:0] exp_q[$];
   logic [31:0] seed = 32'h00000e77;
   int n_fail = 0, total_checks = 0, cyc = 0;
   rpsq_host u_rpsq_host (.clk_in(clk_in), .want_w_in(ww), .want_r_in(wr),
      .wlan_req_out(wq), .radio_req_out(rq));
   rpsq_top u_rpsq_top (.clk_in(clk_in), .resetn_in(resetn_in),
      .wlan_power_request_in(wq), .short_range_radio_power_request_in(rq),
      .regulator_enable_out(reg_en), .wlan_resetn_out(w_rst),
      .radio_resetn_out(r_rst), .por_active_out(por),
      .discharge_busy_out(busy), .bus_ready_out(rdy), .state_out(st));
   initial forever #5 clk_in = ~clk_in;
   task automatic chk(input logic [4:0] seen, input logic [4:0] ev,
      input string what);
      total_checks++;
      if (seen !== ev) begin
         n_fail++;
         $display("FAIL %s exp %h seen %h", what, ev, seen);
      end
   endtask : chk
   task automatic close_out;
      if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction : xs
   // Hold two cycles so the registered answer is settled when noted
   task automatic step(input logic w, input logic r);
      @(posedge clk_in) #1;
      ww = w;
      wr = r;
      @(posedge clk_in) #1;
      exp_q.push_back({w | r, w, r, (w | r) ? RPSQ_ON : RPSQ_OFF});
   endtask : step
   always @(negedge clk_in) begin
      if (exp_q.size() > 0)
         chk({reg_en, w_rst, r_rst, st}, exp_q.pop_front(), "outs");
   end
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         close_out();
      end
   end
   initial begin
      repeat (8) @(posedge clk_in);
      chk({2'h0, por, rdy, reg_en}, 5'h04, "reset");
      #1 resetn_in = 1;
      repeat (5) @(posedge clk_in);
      #1 chk({4'h0, por}, 5'h01, "por held");
      while (por) @(posedge clk_in) #1;
      chk({4'h0, por}, 5'h00, "por");
      // Never both low here: the host would then stay off
      repeat (60) begin
         seed = xs(seed);
         step(seed[0] | !seed[1], seed[1]);
      end
      step(0, 0);
      chk({3'h0, busy, rdy}, 5'h02, "busy");
      repeat (2) @(posedge clk_in);
      close_out();
   end
endmodule : rpsq_top_tb
